// File: logic/gcr_pkg.sv
// Package for the general configuration register slice.
// Assumes a serial interface engine outside that issues word accesses.
package gcr_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam int          GCR_AW            = 7;
    localparam int          GCR_DW            = 32;
    localparam logic [6:0]  GCR_ADDR_NODE     = 7'h03;
    localparam logic [6:0]  GCR_ADDR_INPUT_PIN_SNAPSHOT     = 7'h04;
    localparam logic [6:0]  GCR_ADDR_COMPARE  = 7'h05;

    // ****************************************************************
    // Field layout
    // ****************************************************************
    localparam int          GCR_NODE_ADDR_LSB = 0;
    localparam int          GCR_NODE_ADDR_W   = 8;
    localparam int          GCR_DELAY_LSB     = 8;
    localparam int          GCR_DELAY_W       = 4;
    localparam int          GCR_SNAP_LEFT     = 0;
    localparam int          GCR_SNAP_RIGHT    = 2;
    localparam int          GCR_SNAP_DRV_EN   = 4;
    localparam int          GCR_SNAP_ENC_IDX  = 5;
    localparam int          GCR_SNAP_EXTERNAL_STEP_SOURCE  = 6;
    localparam int          GCR_SNAP_SWCOMP   = 7;
    localparam int          GCR_SNAP_REV_LSB  = 24;
    localparam int          GCR_REV_W         = 8;
    localparam int          GCR_POL_BIT       = 0;

    // ****************************************************************
    // Reset values and delay scale
    // ****************************************************************
    localparam logic [11:0] GCR_NODE_RST      = 12'h000;
    localparam logic        GCR_POL_RST       = 1'b1;
    localparam logic [31:0] GCR_COMPARE_RST   = 32'h0000_0000;
    localparam int          GCR_BITS_PER_STEP = 8;
    localparam int          GCR_DELAY_OUT_W   = 7;
    localparam int          GCR_SYNC_STAGES   = 3;
    localparam int          GCR_NUM_PINS      = 7;

    // Register access request from the interface engine
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [6:0]        addr;
        logic [31:0]       wdata;
    } gcr_req_t;

    // Raw external pin levels, asynchronous to clk_sys
    typedef struct packed {
        logic              addr_incr;
        logic              swcomp;
        logic              external_step_source;
        logic              enc_idx;
        logic              drv_en;
        logic              right_ref;
        logic              left_ref;
    } gcr_pins_t;

    // Reply delay in bit times: codes 2n and 2n+1 give (2n+1)*8
    function automatic logic [6:0] gcr_delay_bits(input logic [3:0] code);
        gcr_delay_bits = 7'({3'h0, code | 4'h1} * GCR_BITS_PER_STEP);
    endfunction

endpackage

// File: logic/gcr_general_config.sv
// General configuration registers: node address, input snapshot,
// output polarity and position compare with pulse on diag pin two.
// Assumes a serial engine on clk_sys issuing one access per cycle
// and an actual position produced on the same clock.
//
// Behaviour
// - Node address comes from bits 7..0 of the node register.
// - Active address-increment pin makes the device answer address plus one.
// - Reply delay codes 2n and 2n+1 give (2n+1)*8 bit times.
// - Snapshot bits 0,2,4,5 show left, right, driver enable, index.
// - Snapshot bit 6 shows the external step source selection.
// - Snapshot bit 7 shows the switch comparator output.
// - Snapshot bits 31..24 hold a fixed revision code.
// - Serial out pin level follows the output polarity bit.
// - Serial out pin serves as next-address output for the chain.
// - Output polarity bit resets to one.
// - Position pulse is high the cycle after actual position equals compare value.
// - Position pulse goes low once the positions mismatch.
// - Position pulse appears on the second diagnostic pin.
// - Diag pin two: open collector low active, or push-pull high active.
`timescale 1ns/1ps
`default_nettype none

module gcr_general_config #(
    parameter logic [7:0] REVISION = 8'hA5  // Arbitrary revision code
) (
    input  wire logic              clk_sys,         // System clock
    input  wire logic              srst,            // Sync reset, high
    input  wire gcr_pkg::gcr_req_t req,             // Register access
    output logic [31:0]            rdata,           // Read data, registered
    output logic                   rvalid,          // Read data valid pulse
    input  wire gcr_pkg::gcr_pins_t pins,           // Raw input pins
    input  wire logic [31:0]       actual_position, // Actual position
    input  wire logic              diag_two_drive_type, // 1 push-pull
    output logic [7:0]             uart_node_address,   // Effective address
    output logic [6:0]             reply_delay_bits,    // Delay, bit times
    output logic                   serial_out_pin,      // Next-address out
    output logic                   position_pulse,      // Match, high
    output logic                   second_diagnostic_pin_o,  // Pin level
    output logic                   second_diagnostic_pin_oe  // Pin drive
);
    import gcr_pkg::*;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    // Three stages; a change counts only once stages two and three agree.
    logic [GCR_NUM_PINS-1:0] sync1_r;
    logic [GCR_NUM_PINS-1:0] sync2_r;
    logic [GCR_NUM_PINS-1:0] sync3_r;
    logic [GCR_NUM_PINS-1:0] pin_st_r;
    logic [GCR_NUM_PINS-1:0] pin_st_nxt;
    gcr_pins_t               pin_st;

    assign pin_st_nxt = (sync2_r == sync3_r) ? sync3_r : pin_st_r;
    assign pin_st     = gcr_pins_t'(pin_st_r);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sync1_r  <= '0;
            sync2_r  <= '0;
            sync3_r  <= '0;
            pin_st_r <= '0;
        end else begin
            sync1_r  <= pins;
            sync2_r  <= sync1_r;
            sync3_r  <= sync2_r;
            pin_st_r <= pin_st_nxt;
        end
    end

    // ****************************************************************
    // Register writes
    // ****************************************************************
    logic [11:0] node_r;
    logic        pol_r;
    logic [31:0] compare_r;
    logic        wr_node;
    logic        wr_pol;
    logic        wr_cmp;

    assign wr_node = req.wr && (req.addr == GCR_ADDR_NODE);
    // Shared address: a write only reaches the polarity bit
    assign wr_pol  = req.wr && (req.addr == GCR_ADDR_INPUT_PIN_SNAPSHOT);
    assign wr_cmp  = req.wr && (req.addr == GCR_ADDR_COMPARE);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            node_r    <= GCR_NODE_RST;
            pol_r     <= GCR_POL_RST;
            compare_r <= GCR_COMPARE_RST;
        end else begin
            if (wr_node) begin
                node_r <= req.wdata[GCR_DELAY_LSB+GCR_DELAY_W-1:0];
            end
            if (wr_pol) begin
                pol_r <= req.wdata[GCR_POL_BIT];
            end
            if (wr_cmp) begin
                compare_r <= req.wdata;
            end
        end
    end

    // ****************************************************************
    // Node address and reply delay
    // ****************************************************************
    logic [7:0] node_field;
    logic [3:0] delay_field;

    assign node_field  = node_r[GCR_NODE_ADDR_LSB +: GCR_NODE_ADDR_W];
    assign delay_field = node_r[GCR_DELAY_LSB +: GCR_DELAY_W];
    // No saturation: 255 would wrap, so software stays below 255
    assign uart_node_address = 8'(node_field
                               + {7'h00, pin_st.addr_incr});
    assign reply_delay_bits  = gcr_delay_bits(delay_field);

    // ****************************************************************
    // Input snapshot and read port
    // ****************************************************************
    logic [31:0] snapshot;
    logic [31:0] rdata_nxt;

    always_comb begin
        snapshot = '0;
        snapshot[GCR_SNAP_LEFT]    = pin_st.left_ref;
        snapshot[GCR_SNAP_RIGHT]   = pin_st.right_ref;
        snapshot[GCR_SNAP_DRV_EN]  = pin_st.drv_en;
        snapshot[GCR_SNAP_ENC_IDX] = pin_st.enc_idx;
        snapshot[GCR_SNAP_EXTERNAL_STEP_SOURCE] = pin_st.external_step_source;
        snapshot[GCR_SNAP_SWCOMP]  = pin_st.swcomp;
        snapshot[GCR_SNAP_REV_LSB +: GCR_REV_W] = REVISION;
    end

    // Write-only and unmapped addresses read as zero
    assign rdata_nxt = (req.addr == GCR_ADDR_INPUT_PIN_SNAPSHOT) ? snapshot
                                                   : '0;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rdata  <= '0;
            rvalid <= 1'b0;
        end else begin
            rvalid <= req.rd;
            if (req.rd) begin
                rdata <= rdata_nxt;
            end
        end
    end

    // ****************************************************************
    // Serial out and position pulse
    // ****************************************************************
    logic pp_r;

    assign serial_out_pin = pol_r;

    // Registered compare; pulse lags the position by one cycle
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pp_r <= 1'b0;
        end else begin
            pp_r <= (actual_position == compare_r);
        end
    end

    assign position_pulse           = pp_r;
    // Open collector pulls low on a pulse; push-pull drives the level
    assign second_diagnostic_pin_o  = diag_two_drive_type ? pp_r
                                                          : 1'b0;
    assign second_diagnostic_pin_oe = diag_two_drive_type | pp_r;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    property p_node_write;
        wr_node |=> node_field == $past(req.wdata[7:0]);
    endproperty
    a_node_write: assert property (p_node_write)
        else $error("node addr");

    property p_addr_incr;
        uart_node_address == 8'(node_field + {7'h00, pin_st.addr_incr});
    endproperty
    a_addr_incr: assert property (p_addr_incr)
        else $error("addr incr");

    // Codes pair up: (2*pair+1) steps of eight bit times
    property p_delay;
        reply_delay_bits
            == 7'((2 * 32'(delay_field[3:1]) + 1) * GCR_BITS_PER_STEP);
    endproperty
    a_delay: assert property (p_delay)
        else $error("reply delay");

    property p_snap_read;
        req.rd && req.addr == GCR_ADDR_INPUT_PIN_SNAPSHOT |=>
            rvalid && rdata[7:0] == {$past(pin_st.swcomp),
            $past(pin_st.external_step_source), $past(pin_st.enc_idx),
            $past(pin_st.drv_en), 1'b0, $past(pin_st.right_ref), 1'b0,
            $past(pin_st.left_ref)};
    endproperty
    a_snap_read: assert property (p_snap_read)
        else $error("snapshot");

    property p_revision;
        req.rd && req.addr == GCR_ADDR_INPUT_PIN_SNAPSHOT |=> rdata[31:24] == REVISION;
    endproperty
    a_revision: assert property (p_revision)
        else $error("revision");

    property p_pol_write;
        wr_pol |=> serial_out_pin == $past(req.wdata[0]);
    endproperty
    a_pol_write: assert property (p_pol_write)
        else $error("polarity");

    property p_pol_reset;
        @(posedge clk_sys) disable iff (1'b0) srst |=> serial_out_pin;
    endproperty
    a_pol_reset: assert property (p_pol_reset)
        else $error("pol reset");

    property p_pp_match;
        actual_position == compare_r |=> position_pulse;
    endproperty
    a_pp_match: assert property (p_pp_match)
        else $error("pp high");

    property p_pp_mismatch;
        actual_position != compare_r |=> !position_pulse;
    endproperty
    a_pp_mismatch: assert property (p_pp_mismatch)
        else $error("pp low");

    property p_diag_pin;
        position_pulse ? (second_diagnostic_pin_oe
            && second_diagnostic_pin_o == diag_two_drive_type)
        : (second_diagnostic_pin_oe == diag_two_drive_type
            && !second_diagnostic_pin_o);
    endproperty
    a_diag_pin: assert property (p_diag_pin)
        else $error("diag pin");

    property p_shared_write;
        wr_pol |=> $stable(node_r) && $stable(compare_r);
    endproperty
    a_shared_write: assert property (p_shared_write)
        else $error("shared");

    // A pin level is taken over only once stages two and three agree
    property p_sync_settle;
        !$stable(pin_st_r) |-> $past(sync2_r) == $past(sync3_r)
            && pin_st_r == $past(sync3_r);
    endproperty
    a_sync_settle: assert property (p_sync_settle)
        else $error("pin settle");

    c_snap_read: cover property (req.rd && req.addr == GCR_ADDR_INPUT_PIN_SNAPSHOT ##1 rvalid);
    c_pp_pulse:  cover property (!position_pulse ##1 position_pulse
                                 ##1 !position_pulse);
    c_incr:      cover property (pin_st.addr_incr && node_field != 8'h00);
    c_pol_low:   cover property (wr_pol ##1 !serial_out_pin);

endmodule // gcr_general_config

`default_nettype wire

// File: dv/gcr_board_model.sv
// Board model for diagnostic pin two: the line and its pull-up.
// Assumes the device splits the pin into level and drive enable.
`timescale 1ns/1ps
`default_nettype none

module gcr_board_model (
    input  wire logic pin_o,    // Level from the device
    input  wire logic pin_oe,   // Drive enable from the device
    output logic      diag_line // Resolved board line
);
    // Pull-up wins whenever the device lets go of the line
    assign diag_line = pin_oe ? pin_o : 1'b1;
endmodule // gcr_board_model

`default_nettype wire

// File: dv/test_general_config_registers.sv
// Self-checking bench for the general configuration registers.
// Assumes the board model for the pull-up on diag pin two.
`timescale 1ns/1ps
`default_nettype none

module test_general_config_registers;
    import gcr_pkg::*;
    localparam logic [7:0] REV = 8'h3C; // Arbitrary revision code
    logic        clk_sys;
    logic        srst;
    gcr_req_t    req;
    gcr_pins_t   pins;
    logic [31:0] actual_position;
    logic        diag_two_drive_type;
    logic [31:0] rdata;
    logic        rvalid;
    logic [7:0]  node_addr;
    logic [6:0]  delay_bits;
    logic        serial_out;
    logic        pp;
    logic        pin_o;
    logic        pin_oe;
    logic        diag_line;
    logic [31:0] got;
    int          fail_count = 0;
    int          n_checks = 0;

    gcr_general_config #(.REVISION(REV)) dut_u (
        .clk_sys(clk_sys), .srst(srst), .req(req), .rdata(rdata),
        .rvalid(rvalid), .pins(pins), .actual_position(actual_position),
        .diag_two_drive_type(diag_two_drive_type),
        .uart_node_address(node_addr), .reply_delay_bits(delay_bits),
        .serial_out_pin(serial_out), .position_pulse(pp),
        .second_diagnostic_pin_o(pin_o), .second_diagnostic_pin_oe(pin_oe));
    gcr_board_model board_u (
        .pin_o(pin_o), .pin_oe(pin_oe), .diag_line(diag_line));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // ****************************************************************
    // Access and check tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] g, e, input string m);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        req.wr <= 1'b1;
        req.addr <= a;
        req.wdata <= d;
        @(posedge clk_sys);
        req.wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [6:0] a, output logic [31:0] d);
        int i;
        @(posedge clk_sys);
        req.rd <= 1'b1;
        req.addr <= a;
        @(posedge clk_sys);
        req.rd <= 1'b0;
        #1;
        // The valid pulse stands only until the next edge
        for (i = 0; i < 4; i++) begin
            if (rvalid === 1'b1) break;
            tick(1);
        end
        // Waiting too long counts as a failure and ends the run
        if (rvalid !== 1'b1) begin
            fail_count++;
            conclude();
        end else begin
            chk(32'(i), 32'h0, "read latency");
            d = rdata;
            tick(1);
            chk(32'(rvalid), 32'h0, "read pulse");
        end
    endtask

    function automatic logic [31:0] exp_snap(input gcr_pins_t p);
        return {REV, 16'h0, p.swcomp, p.external_step_source, p.enc_idx, p.drv_en,
                1'b0, p.right_ref, 1'b0, p.left_ref};
    endfunction

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        srst = 1'b1;
        req = '0;
        pins = '0;
        // Off the reset compare value, so no pulse before a real match
        actual_position = 32'h0000_0001;
        diag_two_drive_type = 1'b0;
        repeat (12) @(posedge clk_sys);
        srst <= 1'b0;
        tick(1);
        chk(32'(serial_out), 32'h1, "polarity reset");
        chk(32'(node_addr), 32'h0, "node reset");
        chk(32'(delay_bits), 32'h8, "delay reset");
        chk(32'(pp), 32'h0, "pulse reset");
        chk(32'(diag_line), 32'h1, "diag idle");
        for (int c = 0; c < 16; c++) begin
            wr(GCR_ADDR_NODE, {20'h0, 4'(c), 8'(c*16+3)});
            chk(32'(delay_bits), 32'((c | 1) * 8), "delay");
            chk(32'(node_addr), 32'(c * 16 + 3), "node");
        end
        wr(GCR_ADDR_NODE, 32'h0000_00FD);
        chk(32'(diag_line), 32'h1, "diag released");
        @(posedge clk_sys);
        pins <= 7'h55;
        tick(6);
        chk(32'(node_addr), 32'hFE, "incremented");
        rd(GCR_ADDR_INPUT_PIN_SNAPSHOT, got);
        chk(got, exp_snap(7'h55), "snapshot a");
        @(posedge clk_sys);
        pins <= 7'h2A;
        tick(6);
        chk(32'(node_addr), 32'hFD, "plain");
        rd(GCR_ADDR_INPUT_PIN_SNAPSHOT, got);
        chk(got, exp_snap(7'h2A), "snapshot b");
        wr(GCR_ADDR_INPUT_PIN_SNAPSHOT, 32'hFFFF_FFFE);
        chk(32'(serial_out), 32'h0, "polarity low");
        rd(GCR_ADDR_INPUT_PIN_SNAPSHOT, got);
        chk(got, exp_snap(7'h2A), "snapshot kept");
        // Mid-run reset must bring the chain output back high
        @(posedge clk_sys);
        srst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        srst <= 1'b0;
        tick(1);
        chk(32'(serial_out), 32'h1, "polarity re-reset");
        chk(32'(node_addr), 32'h0, "node re-reset");
        wr(GCR_ADDR_INPUT_PIN_SNAPSHOT, 32'h0000_0000);
        chk(32'(serial_out), 32'h0, "polarity low again");
        wr(GCR_ADDR_INPUT_PIN_SNAPSHOT, 32'h0000_0001);
        chk(32'(serial_out), 32'h1, "polarity high");
        // Write-only and unmapped places read back zero
        wr(GCR_ADDR_COMPARE, 32'h8000_0001);
        rd(GCR_ADDR_NODE, got);
        chk(got, 32'h0, "node read");
        rd(GCR_ADDR_COMPARE, got);
        chk(got, 32'h0, "compare read");
        rd(7'h7F, got);
        chk(got, 32'h0, "unmapped read");
        @(posedge clk_sys);
        actual_position <= 32'h8000_0001;
        #1;
        chk(32'(pp), 32'h0, "pulse lag");
        tick(1);
        chk(32'(pp), 32'h1, "pulse on match");
        chk(32'(diag_line), 32'h0, "oc active low");
        @(posedge clk_sys);
        diag_two_drive_type <= 1'b1;
        tick(1);
        chk({pin_oe, diag_line}, 32'h3, "pp high");
        @(posedge clk_sys);
        actual_position <= 32'h0000_0001;
        tick(1);
        chk(32'(pp), 32'h0, "pulse off");
        chk({pin_oe, diag_line}, 32'h2, "pp driven low");
        @(posedge clk_sys);
        diag_two_drive_type <= 1'b0;
        tick(1);
        chk({pin_oe, diag_line}, 32'h1, "oc released");
        conclude();
    end
endmodule // test_general_config_registers

`default_nettype wire
